// [rtl/tty_route_command_control.sv]
// command interpreter, route table and panel indicators of the teletype switch
`default_nettype none
`include "tty_route_defs.svh"
module tty_route_command_control
  import tty_route_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic en_in,
  // panel buttons, asynchronous
  input wire logic [21:0] src_btn_in,
  input wire logic [17:0] load_btn_in,
  input wire logic join_btn_in,
  input wire logic drop_btn_in,
  input wire logic discard_btn_in,
  input wire logic fault_reset_button_in,
  input wire logic status_btn_in,
  // equipment signals, asynchronous
  input wire logic [17:0] load_step_in,
  input wire logic loop_a_ok_in,
  input wire logic loop_b_ok_in,
  input wire logic power_restored_in,
  // avalon-mm slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // panel indicators
  output logic [21:0] src_green_out,
  output logic [21:0] src_red_out,
  output logic [21:0] src_yellow_out,
  output logic [17:0] load_green_out,
  output logic [17:0] load_red_out,
  output logic [17:0] load_yellow_out,
  output logic lockout_out,
  // equipment steering
  output logic [1:0] td_step_out,
  output logic [1:0] diag_tap_out,
  output logic loop_b_active_out,
  output logic loop_fault_out
);
  ctl_regs_t q; // registered state
  ctl_regs_t d; // next state
  logic [`SYNC_W-1:0] sy_lvl; // synchronised levels
  logic [`SYNC_W-1:0] sy_rise; // one-cycle press pulses
  logic [17:0] cur_mask; // loads of selected source, retained routes excluded
  logic [17:0] all_mask; // every load of selected source
  logic [17:0] new_bit; // one-hot selected load
  logic [17:0] nxt_mask; // loads of source if the join went through, retained routes excluded
  logic [21:0][17:0] hit; // route table seen per source
  logic [21:0] src_used; // source carries at least one load
  logic [21:0] src_red_w; // red/black source feeds a black load
  logic [17:0] ld_red_w; // load is black and fed from red/black source
  logic [21:0] src_yel_w; // source marked faulty
  logic [17:0] ld_yel_w; // load marked faulty
  logic [17:0] step_td1; // step-capable loads feeding reader 1
  logic [17:0] step_td2; // step-capable loads feeding reader 2
  logic use_b; // loop supervisor outputs
  logic loop_fault;
  logic is_kb, is_td, is_rb; // class of selected source
  logic sel_bad, busy, mix, kb_bc, too_many, td_bad, viol; // join checks
  logic join_ev, drop_ev, discard_ev, reset_ev, pwr_ev, stat_lvl; // panel events
  logic stat_on; // status view active
  // class masks as named constants so that single bits can be picked
  localparam logic [17:0] LD_NONSEC = `LOAD_NONSEC_MASK, LD_STEP = `LOAD_STEP_MASK;
  localparam logic [21:0] SR_KB = `SRC_KB_MASK, SR_TD = `SRC_TD_MASK, SR_RB = `SRC_REDBLACK_MASK;

  // ones counter for class checks
  function automatic logic [4:0] count_ones(input logic [21:0] v);
    logic [4:0] c;
    c = 5'h00;
    for (int k = 0; k < 22; k++) begin
      c = c + {4'h0, v[k]};
    end
    return c;
  endfunction : count_ones

  // lowest set bit of a press vector
  function automatic logic [4:0] first_one(input logic [21:0] v);
    logic [4:0] f;
    f = 5'h00;
    for (int k = 21; k >= 0; k--) begin
      if (v[k]) begin
        f = 5'(k);
      end
    end
    return f;
  endfunction : first_one

  // every pin passes two flops before use
  button_sync #(.W(`SYNC_W)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .en_in(en_in),
    .raw_in({power_restored_in, loop_b_ok_in, loop_a_ok_in, load_step_in, status_btn_in,
      fault_reset_button_in, discard_btn_in, drop_btn_in, join_btn_in, load_btn_in,
      src_btn_in}),
    .level_out(sy_lvl),
    .rise_out(sy_rise)
  );

  // loop supervisor, steered by the control register
  loop_monitor u_loop (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .en_in(en_in),
    .mode_in(loop_mode_t'(q.loop_mode)),
    .a_ok_in(sy_lvl[`SY_A_OK]),
    .b_ok_in(sy_lvl[`SY_B_OK]),
    .use_b_out(use_b),
    .fault_out(loop_fault)
  );

  assign join_ev = sy_rise[`SY_JOIN];
  assign drop_ev = sy_rise[`SY_DROP];
  assign discard_ev = sy_rise[`SY_DISCARD];
  assign reset_ev = sy_rise[`SY_FRESET];
  assign pwr_ev = sy_rise[`SY_POWER];
  assign stat_lvl = sy_lvl[`SY_STATUS];
  assign stat_on = stat_lvl && q.src_v;

  // per-load view of the route table
  for (genvar i = 0; i < `NUM_LOAD; i++) begin : g_load
    assign all_mask[i] = q.rt_v[i] && (q.rt_src[i] == q.src_idx);
    assign cur_mask[i] = all_mask[i] && !q.rt_old[i];
    assign new_bit[i] = q.load_v && (q.load_idx == 5'(i));
    assign ld_red_w[i] = q.rt_v[i] && LD_NONSEC[i]
      && SR_RB[q.rt_src[i]];
    assign ld_yel_w[i] = q.lockout && q.flt_load_v && (q.flt_load == 5'(i));
    // step is only wired back from loads that provide one
    assign step_td1[i] = q.rt_v[i] && LD_STEP[i] && (q.rt_src[i] == `SRC_TD1)
      && sy_lvl[`SY_STEP_LSB + i];
    assign step_td2[i] = q.rt_v[i] && LD_STEP[i] && (q.rt_src[i] == `SRC_TD2)
      && sy_lvl[`SY_STEP_LSB + i];
  end

  // per-source view of the route table
  for (genvar j = 0; j < `NUM_SRC; j++) begin : g_src
    for (genvar i = 0; i < `NUM_LOAD; i++) begin : g_hit
      assign hit[j][i] = q.rt_v[i] && (q.rt_src[i] == 5'(j));
    end
    assign src_used[j] = |hit[j];
    assign src_red_w[j] = SR_RB[j] && |(hit[j] & `LOAD_NONSEC_MASK);
    assign src_yel_w[j] = q.lockout && q.flt_src_v && (q.flt_src == 5'(j));
  end

  // restriction checks; retained routes are left out of the counts
  assign nxt_mask = cur_mask | new_bit;
  assign is_kb = SR_KB[q.src_idx];
  assign is_td = SR_TD[q.src_idx];
  assign is_rb = is_kb || is_td;
  assign sel_bad = q.two_src || q.two_load || !q.src_v || !q.load_v;
  assign busy = q.load_v && q.rt_v[q.load_idx];
  assign mix = is_rb && |(nxt_mask & `LOAD_CRYPTO_MASK)
    && |(nxt_mask & `LOAD_NONSEC_MASK);
  assign kb_bc = is_kb && (count_ones({4'h0, nxt_mask & `LOAD_BCAST_MASK}) > 5'd1);
  assign too_many = count_ones({4'h0, nxt_mask}) > `MAX_LOADS_PER_SRC;
  assign td_bad = is_td && ((count_ones({4'h0, nxt_mask & `LOAD_BCAST_MASK}) > 5'd1)
    || (count_ones({4'h0, nxt_mask & `LOAD_STEP_MASK}) > 5'd1));
  assign viol = sel_bad || busy || mix || kb_bc || too_many || td_bad;

  // next state: commands, selections, display, register bus
  always_comb begin
    d = q;
    if (pwr_ev) begin
      // power return: keep routes but leave them out of the class and count checks of later joins
      d.blank = 1'b1;
      d.rt_old = q.rt_v;
    end else if (q.st == CTL_LOCKOUT) begin
      if (reset_ev) begin
        d.st = CTL_READY;
        d.flt_src_v = 1'b0;
        d.flt_load_v = 1'b0;
      end
    end else if (discard_ev) begin
      d.src_v = 1'b0;
      d.load_v = 1'b0;
      d.two_src = 1'b0;
      d.two_load = 1'b0;
    end else if (join_ev) begin
      d.src_v = 1'b0;
      d.load_v = 1'b0;
      d.two_src = 1'b0;
      d.two_load = 1'b0;
      d.blank = 1'b0;
      if (viol) begin
        // refuse the command and mark the buttons involved
        d.st = CTL_LOCKOUT;
        d.flt_src_v = q.src_v;
        d.flt_src = q.src_idx;
        d.flt_load_v = q.load_v;
        d.flt_load = q.load_idx;
      end else begin
        // new route, or one more load on an existing source
        d.rt_v[q.load_idx] = 1'b1;
        d.rt_old[q.load_idx] = 1'b0;
        d.rt_src[q.load_idx] = q.src_idx;
      end
    end else if (drop_ev) begin
      d.src_v = 1'b0;
      d.load_v = 1'b0;
      d.two_src = 1'b0;
      d.two_load = 1'b0;
      d.blank = 1'b0;
      if (q.load_v && !q.two_load) begin
        d.rt_v[q.load_idx] = 1'b0;
        d.rt_old[q.load_idx] = 1'b0;
      end
    end else begin
      // latch presses; a second press of the same kind is remembered
      if (|sy_rise[21:0]) begin
        d.two_src = q.two_src || q.src_v || (count_ones(sy_rise[21:0]) > 5'd1);
        d.src_v = 1'b1;
        d.src_idx = first_one(sy_rise[21:0]);
      end
      if (|sy_rise[39:22]) begin
        d.two_load = q.two_load || q.load_v
          || (count_ones({4'h0, sy_rise[39:22]}) > 5'd1);
        d.load_v = 1'b1;
        d.load_idx = first_one({4'h0, sy_rise[39:22]});
      end
    end
    d.lockout = (d.st == CTL_LOCKOUT);
    // green and red indicators follow the table; status narrows them, blank hides them
    if (q.blank) begin
      d.src_grn = '0;
      d.ld_grn = '0;
      d.src_red = '0;
      d.ld_red = '0;
    end else if (stat_on) begin
      d.src_grn = src_used & (22'(1) << q.src_idx);
      d.ld_grn = all_mask;
      d.src_red = src_red_w & (22'(1) << q.src_idx);
      d.ld_red = ld_red_w & all_mask;
    end else begin
      d.src_grn = src_used;
      d.ld_grn = q.rt_v;
      d.src_red = src_red_w;
      d.ld_red = ld_red_w;
    end
    d.src_yel = src_yel_w;
    d.ld_yel = ld_yel_w;
    d.td_step = {|step_td2, |step_td1};
    d.diag_tap = {q.rt_v[`LOAD_CH3], q.rt_v[`LOAD_CH2]};
    // avalon slave: one wait cycle, write commits when waitrequest is low
    d.av_wait = !((avs_read_in || avs_write_in) && q.av_wait);
    if (avs_write_in && !q.av_wait && avs_address_in == `REG_CTRL && avs_byteenable_in[0]) begin
      d.loop_mode = avs_writedata_in[1:0];
    end
    if (avs_read_in && q.av_wait) begin
      unique case (avs_address_in)
        `REG_CTRL: d.av_rdata = {30'h0, q.loop_mode};
        `REG_STATUS: d.av_rdata = {19'h0, count_ones({4'h0, q.rt_v}), 4'h0, q.blank,
          loop_fault, use_b, q.lockout};
        default: d.av_rdata = 32'h0; // unmapped reads as zero
      endcase
    end
  end

  // state register; reset gives ready, empty table, loop auto
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
      q.av_wait <= 1'b1;
      q.loop_mode <= `CTRL_RESET;
    end else if (en_in) begin
      q <= d;
    end
  end

  assign avs_readdata_out = q.av_rdata;
  assign avs_waitrequest_out = q.av_wait;
  assign src_green_out = q.src_grn;
  assign src_red_out = q.src_red;
  assign src_yellow_out = q.src_yel;
  assign load_green_out = q.ld_grn;
  assign load_red_out = q.ld_red;
  assign load_yellow_out = q.ld_yel;
  assign lockout_out = q.lockout;
  assign td_step_out = q.td_step;
  assign diag_tap_out = q.diag_tap;
  assign loop_b_active_out = use_b;
  assign loop_fault_out = loop_fault;

  // checks on the command interpreter
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  logic ready_cmd;
  assign ready_cmd = en_in && !pwr_ev && q.st == CTL_READY;

  chk_bad_join_locks: assert property (ready_cmd && !discard_ev && join_ev && viol
    |=> lockout_out)
    else $error("violating join did not lock out");
  chk_lockout_holds: assert property (en_in && !pwr_ev && q.st == CTL_LOCKOUT && !reset_ev
    |=> q.st == CTL_LOCKOUT && $stable(q.rt_v))
    else $error("lockout left without fault reset");
  chk_busy_reject: assert property (ready_cmd && !discard_ev && join_ev && busy
    |=> $stable(q.rt_src) && q.flt_load_v)
    else $error("join onto connected load accepted");
  chk_load_limit: assert property (ready_cmd && !discard_ev && join_ev && too_many
    |=> q.lockout ##1 lockout_out)
    else $error("sixteenth load accepted");
  chk_join_routes: assert property (ready_cmd && !discard_ev && join_ev && !viol
    |=> q.rt_v[$past(q.load_idx)] && q.rt_src[$past(q.load_idx)] == $past(q.src_idx))
    else $error("valid join made no route");
  chk_drop_one: assert property (ready_cmd && !discard_ev && !join_ev && drop_ev && q.load_v
    && !q.two_load |=> q.rt_v == ($past(q.rt_v) & ~$past(new_bit)))
    else $error("drop changed more than one load");
  chk_discard_clears: assert property (ready_cmd && discard_ev
    |=> !q.src_v && !q.load_v && $stable(q.rt_v))
    else $error("discard left a selection");
  chk_status_view: assert property (en_in && stat_on && !q.blank
    |=> (load_green_out & ~$past(all_mask)) == 18'h0)
    else $error("status view lit a foreign load");
  chk_power_blank: assert property (en_in && pwr_ev
    |=> q.blank && q.rt_v == $past(q.rt_v) ##1 src_green_out == 22'h0)
    else $error("power return lost routes or lit panel");

  cov_join_ok: cover property (ready_cmd && join_ev && !viol);
  cov_lockout_reset: cover property (q.lockout ##[1:20] !q.lockout);
  cov_drop: cover property (ready_cmd && drop_ev && q.load_v);
  cov_status: cover property (stat_on && |all_mask);
endmodule : tty_route_command_control
`default_nettype wire

// [rtl/tty_route_defs.svh]
// constants of the teletype routing command logic: sizes, indices, masks, offsets
`ifndef TTY_ROUTE_DEFS_SVH
`define TTY_ROUTE_DEFS_SVH
// panel population
`define NUM_SRC 22
`define NUM_LOAD 18
`define IDX_W 5
`define MAX_LOADS_PER_SRC 5'd15
// source indices used by name
`define SRC_TD1 5'd2
`define SRC_TD2 5'd3
// load indices used by name
`define LOAD_CH2 5'd11
`define LOAD_CH3 5'd12
// source classes: keyboards 0-1, tape readers 2-3
`define SRC_KB_MASK 22'h000003
`define SRC_TD_MASK 22'h00000c
`define SRC_REDBLACK_MASK 22'h00000f
// load classes
`define LOAD_CRYPTO_MASK 18'h00300
`define LOAD_NONSEC_MASK 18'h3c080
`define LOAD_BCAST_MASK 18'h01c00
`define LOAD_STEP_MASK 18'h02700
// synchroniser width and field positions
`define SYNC_W 66
`define SY_LOAD_LSB 22
`define SY_JOIN 40
`define SY_DROP 41
`define SY_DISCARD 42
`define SY_FRESET 43
`define SY_STATUS 44
`define SY_STEP_LSB 45
`define SY_A_OK 63
`define SY_B_OK 64
`define SY_POWER 65
// register byte offsets and reset values
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define CTRL_RESET 2'h0
`endif

// [rtl/tty_route_pkg.sv]
// types shared by the teletype routing command logic
`default_nettype none
`include "tty_route_defs.svh"
package tty_route_pkg;
  // command interpreter states
  typedef enum logic {CTL_READY, CTL_LOCKOUT} ctl_state_t;
  // loop selection modes held in the control register
  typedef enum logic [1:0] {LOOP_AUTO, LOOP_FORCE_A, LOOP_FORCE_B} loop_mode_t;
  // whole state of the command interpreter
  typedef struct packed {
    ctl_state_t st;
    logic lockout;
    logic src_v;
    logic [4:0] src_idx;
    logic two_src;
    logic load_v;
    logic [4:0] load_idx;
    logic two_load;
    logic [17:0] rt_v;
    logic [17:0] rt_old;
    logic [17:0][4:0] rt_src;
    logic blank;
    logic flt_src_v;
    logic [4:0] flt_src;
    logic flt_load_v;
    logic [4:0] flt_load;
    logic [21:0] src_grn;
    logic [21:0] src_red;
    logic [21:0] src_yel;
    logic [17:0] ld_grn;
    logic [17:0] ld_red;
    logic [17:0] ld_yel;
    logic [1:0] td_step;
    logic [1:0] diag_tap;
    logic [1:0] loop_mode;
    logic av_wait;
    logic [31:0] av_rdata;
  } ctl_regs_t;
  // loop supervisor state
  typedef struct packed {
    logic use_b;
    logic fault;
  } loop_regs_t;
endpackage : tty_route_pkg
`default_nettype wire

// [rtl/button_sync.sv]
// two-flop synchroniser with registered rising-edge pulses for panel inputs
`default_nettype none
module button_sync #(
  parameter int W = 66
) (
  // clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic en_in,
  // raw pins and clean outputs
  input wire logic [W-1:0] raw_in,
  output logic [W-1:0] level_out,
  output logic [W-1:0] rise_out
);
  // stage one is read only by stage two
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3; // previous settled level, for edge detection
    logic [W-1:0] rise;
  } sync_regs_t;
  sync_regs_t q;
  sync_regs_t d;

  // next state: shift and mark new highs
  always_comb begin
    d = q;
    d.s1 = raw_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // edge taken between settled stages, so stage one feeds stage two alone
    d.rise = q.s2 & ~q.s3;
  end

  // registers frozen while enable is low
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else if (en_in) begin
      q <= d;
    end
  end

  assign level_out = q.s2;
  assign rise_out = q.rise;
endmodule : button_sync
`default_nettype wire

// [rtl/loop_monitor.sv]
// redundant loop supervisor: automatic changeover or forced choice
`default_nettype none
module loop_monitor
  import tty_route_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic en_in,
  // mode and loop health, already synchronised
  input wire tty_route_pkg::loop_mode_t mode_in,
  input wire logic a_ok_in,
  input wire logic b_ok_in,
  // active loop and fault flag
  output logic use_b_out,
  output logic fault_out
);
  loop_regs_t q;
  loop_regs_t d;

  // choose loop; a degraded active loop hands over only to a healthy one
  always_comb begin
    d = q;
    d.fault = !a_ok_in || !b_ok_in;
    unique case (mode_in)
      LOOP_FORCE_A: d.use_b = 1'b0;
      LOOP_FORCE_B: d.use_b = 1'b1;
      default: begin
        // code 3 also lands here and behaves as automatic
        if (q.use_b && !b_ok_in && a_ok_in) begin
          d.use_b = 1'b0;
        end else if (!q.use_b && !a_ok_in && b_ok_in) begin
          d.use_b = 1'b1;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else if (en_in) begin
      q <= d;
    end
  end

  assign use_b_out = q.use_b;
  assign fault_out = q.fault;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  chk_loop_forced: assert property (en_in && mode_in == LOOP_FORCE_B |=> use_b_out)
    else $error("forced loop b not taken");
  chk_loop_switch: assert property (en_in && mode_in == LOOP_AUTO && !use_b_out && !a_ok_in
    && b_ok_in |=> use_b_out)
    else $error("no changeover from degraded loop a");
  cov_loop_change: cover property (en_in && $rose(use_b_out));
endmodule : loop_monitor
`default_nettype wire

// [tb/panel_model.sv]
// operator panel model: presses source, load and command buttons
`default_nettype none
module panel_model (
  // clock
  input wire logic clk_sys_in,
  // buttons: cmd bits are join, drop, discard, fault reset, power back
  output logic [21:0] src_btn_out,
  output logic [17:0] load_btn_out,
  output logic [4:0] cmd_btn_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // buttons rest low, as if pulled down
  initial begin
    src_btn_out = '0;
    load_btn_out = '0;
    cmd_btn_out = '0;
  end
  // one press, held past the synchroniser, then a settle gap for indicators
  task automatic press(input int k, input int i);
    @(posedge clk_sys_in);
    if (k == 0) begin
      src_btn_out[i] <= 1'b1;
    end else if (k == 1) begin
      load_btn_out[i] <= 1'b1;
    end else begin
      cmd_btn_out[i] <= 1'b1;
    end
    repeat (6) @(posedge clk_sys_in);
    src_btn_out <= '0;
    load_btn_out <= '0;
    cmd_btn_out <= '0;
    repeat (9) @(posedge clk_sys_in);
  endtask : press
endmodule : panel_model
`default_nettype wire

// [tb/test_tty_route_command_control.sv]
// self-checking bench of the teletype routing command logic
`default_nettype none
`include "tty_route_defs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("FAIL %0t value mismatch", $time); end end
module test_tty_route_command_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [21:0] src_btn_in, src_green_out, src_red_out;
  logic [17:0] load_btn_in, load_green_out, load_red_out, step = '0;
  logic [4:0] cmd;
  logic [3:0] avs_address_in = '0;
  logic avs_read_in = 1'b0, avs_write_in = 1'b0, avs_waitrequest_out, lockout_out;
  logic [31:0] avs_writedata_in = '0, avs_readdata_out, rd;
  logic [1:0] td_step_out, diag_tap_out;
  logic loop_b_active_out, lock_e = 1'b0, loop_fault_out;
  logic loop_a_ok = 1'b1, loop_b_ok = 1'b1, stat_btn = 1'b0;
  logic [21:0] src_yellow_out, ysrc = '0;
  logic [17:0] load_yellow_out, yld = '0;
  // class tables taken from the shared constants
  logic [21:0] kb = `SRC_KB_MASK, td = `SRC_TD_MASK;
  logic [17:0] cry = `LOAD_CRYPTO_MASK, nsc = `LOAD_NONSEC_MASK;
  logic [17:0] bc = `LOAD_BCAST_MASK, stp = `LOAD_STEP_MASK;
  int rsrc[18];
  int seed = 80555, fail_count = 0, cmp_count = 0, s, l;
  always #12.5 clk_sys_in = ~clk_sys_in;
  panel_model u_panel_model (.clk_sys_in(clk_sys_in), .src_btn_out(src_btn_in),
    .load_btn_out(load_btn_in), .cmd_btn_out(cmd));
  tty_route_command_control u_tty_route_command_control (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .en_in(1'b1), .src_btn_in(src_btn_in), .load_btn_in(load_btn_in),
    .join_btn_in(cmd[0]), .drop_btn_in(cmd[1]), .discard_btn_in(cmd[2]),
    .fault_reset_button_in(cmd[3]), .status_btn_in(stat_btn), .load_step_in(step),
    .loop_a_ok_in(loop_a_ok), .loop_b_ok_in(loop_b_ok), .power_restored_in(cmd[4]),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .src_green_out(src_green_out),
    .src_red_out(src_red_out), .src_yellow_out(src_yellow_out),
    .load_green_out(load_green_out), .load_red_out(load_red_out),
    .load_yellow_out(load_yellow_out), .lockout_out(lockout_out),
    .td_step_out(td_step_out), .diag_tap_out(diag_tap_out),
    .loop_b_active_out(loop_b_active_out), .loop_fault_out(loop_fault_out));
  // prints the counts and the verdict, then stops
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  // number of routes in the reference table
  function automatic int nroutes();
    int n = 0;
    foreach (rsrc[k]) n += (rsrc[k] >= 0);
    return n;
  endfunction : nroutes
  // reference decision on a join of source s to load l
  function automatic bit join_ok(input int s, input int l);
    int n = 0, b = 0, t = 0, c = 0, ns = 0;
    if (rsrc[l] >= 0) return 0;
    foreach (rsrc[k]) if (rsrc[k] == s) begin
      n++;
      b += bc[k];
      t += stp[k];
      c += cry[k];
      ns += nsc[k];
    end
    if (n >= 15) return 0;
    if ((kb[s] | td[s]) && ((cry[l] && ns > 0) || (nsc[l] && c > 0))) return 0;
    if ((kb[s] | td[s]) && bc[l] && b > 0) return 0;
    if (td[s] && stp[l] && t > 0) return 0;
    return 1;
  endfunction : join_ok
  // compares the panel and steering outputs with the reference table
  task automatic check_all();
    logic [21:0] sg, sr;
    logic [17:0] lg, lr;
    logic [1:0] ts;
    sg = '0; sr = '0; lg = '0; lr = '0; ts = '0;
    foreach (rsrc[k]) if (rsrc[k] >= 0) begin
      lg[k] = 1'b1;
      sg[rsrc[k]] = 1'b1;
      lr[k] = nsc[k] && (kb[rsrc[k]] || td[rsrc[k]]);
      sr[rsrc[k]] |= lr[k];
      if (stp[k] && td[rsrc[k]]) ts[rsrc[k] - 2] |= step[k];
    end
    `CHK(load_green_out, lg)
    `CHK(src_green_out, sg)
    `CHK(load_red_out, lr)
    `CHK(src_red_out, sr)
    `CHK(lockout_out, lock_e)
    `CHK(src_yellow_out, ysrc)
    `CHK(load_yellow_out, yld)
    `CHK(td_step_out, ts)
    `CHK(diag_tap_out, lg[12:11])
  endtask : check_all
  // join or drop, then the fault reset if the reference locked out
  task automatic op(input bit j, input int s, input int l);
    if (j) u_panel_model.press(0, s);
    u_panel_model.press(1, l);
    u_panel_model.press(2, j ? 0 : 1);
    if (j && join_ok(s, l)) rsrc[l] = s;
    else if (j) begin
      lock_e = 1'b1;
      ysrc = 22'(1) << s;
      yld = 18'(1) << l;
    end
    else rsrc[l] = -1;
    check_all();
    if (lock_e) begin
      u_panel_model.press(2, 3);
      lock_e = 1'b0;
      ysrc = '0;
      yld = '0;
      check_all();
    end
  endtask : op
  // one avalon access, held until waitrequest is seen low at an edge
  task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] wd);
    int n = 0;
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_writedata_in <= wd;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    if (avs_waitrequest_out !== 1'b0) begin
      fail_count++;
      give_verdict();
    end else begin
      rd = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
    end
  endtask : bus
  // main sequence
  initial begin
    foreach (rsrc[k]) rsrc[k] = -1;
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    check_all();
    for (int k = 0; k < 16; k++) op(1, 4, k);
    for (int k = 0; k < 15; k++) op(0, 0, k);
    u_panel_model.press(0, 0);
    u_panel_model.press(1, 0);
    u_panel_model.press(2, 2);
    op(1, 0, 0);
    op(1, 0, 1);
    op(1, 1, 2);
    u_panel_model.press(0, 0);
    stat_btn <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    `CHK({src_green_out, load_green_out}, {22'h000001, 18'h00003})
    stat_btn <= 1'b0;
    u_panel_model.press(2, 2);
    check_all();
    for (int k = 0; k < 90; k++) begin
      s = $unsigned($random(seed)) % 22;
      l = $unsigned($random(seed)) % 18;
      step <= 18'($random(seed));
      op(($unsigned($random(seed)) % 3) != 0, s, l);
    end
    bus(1'b0, `REG_STATUS, '0);
    `CHK(rd[12:8], 5'(nroutes()))
    bus(1'b1, `REG_CTRL, 32'h2);
    bus(1'b0, `REG_CTRL, '0);
    `CHK(rd[1:0], 2'h2)
    `CHK(loop_b_active_out, 1'b1)
    bus(1'b1, `REG_CTRL, 32'h1);
    repeat (4) @(posedge clk_sys_in);
    `CHK(loop_b_active_out, 1'b0)
    bus(1'b1, `REG_CTRL, 32'h0);
    loop_a_ok <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    `CHK({loop_b_active_out, loop_fault_out}, 2'b11)
    bus(1'b0, `REG_STATUS, '0);
    `CHK(rd[2:1], 2'b11)
    loop_a_ok <= 1'b1;
    bus(1'b0, 4'h8, '0);
    `CHK(rd, 32'h0)
    u_panel_model.press(2, 4);
    `CHK(src_green_out, 22'h0)
    bus(1'b0, `REG_STATUS, '0);
    `CHK({rd[12:8], rd[3]}, {5'(nroutes()), 1'b1})
    give_verdict();
  end
endmodule : test_tty_route_command_control
`default_nettype wire
